// file: wtc_map.svh
// register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WTC_MAP_SVH
`define WTC_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define WTC_ADDR_W        12
`define WTC_OFF_CTRL      12'h000
`define WTC_OFF_STAT      12'h004
`define WTC_OFF_ICLR      12'h008
`define WTC_OFF_IEN       12'h00C

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define WTC_CTRL_W        8
`define WTC_CTRL_RESET    8'h10
`define WTC_BIT_UNLOCK    0
`define WTC_BIT_RUN       1
`define WTC_BIT_FLAG      2
`define WTC_BIT_IRQM      3
`define WTC_PRE_LSB       4
`define WTC_PRE_MSB       7

// ----------------------------------------------------------------
// prescale codes and timing
// ----------------------------------------------------------------
`define WTC_PRE_MAX       4'h7
`define WTC_PRE_IMM       4'h8
`define WTC_CNT_W         16
`define WTC_CNT_FULL      16'hFFFF
`define WTC_XTAL_HZ       32768
`define WTC_CLK_HZ        20000000

// ----------------------------------------------------------------
// event register layout
// ----------------------------------------------------------------
`define WTC_EVT_W         2
`define WTC_EVT_TIMEOUT   0
`define WTC_EVT_REJECT    1
`define WTC_EVT_RESET     2'h0

`endif

// file: wtc_pkg.sv
// types shared by the watchdog files
package wtc_pkg;

    // ----------------------------------------------------------------
    // control register image, bit 7 down to bit 0
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] timeout_prescale_sel;
        logic       irq_instead_of_reset;
        logic       timeout_flag;
        logic       run_and_kick_bit;
        logic       write_unlock_bit;
    } wtc_ctrl_t;

    typedef struct packed {
        logic rejected;
        logic timeout;
    } wtc_evt_t;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } wtc_apb_req_t;

    typedef enum logic {
        LOCK_IDLE,
        LOCK_ARMED
    } wtc_lock_t;

endpackage

// file: wtc_pin_sync.sv
// two-flop synchronisers with rising-edge pulses for asynchronous pins
`timescale 1ns/1ns
module wtc_pin_sync #(
    parameter int N = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] level,
    output logic      [N-1:0] rise
);

    // ----------------------------------------------------------------
    // per-pin chain
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            logic meta;
            logic stable;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta     <= 1'b0;
                    stable   <= 1'b0;
                    level[i] <= 1'b0;
                    rise[i]  <= 1'b0;
                end else begin
                    meta     <= pin_in[i];
                    stable   <= meta;
                    level[i] <= stable;
                    rise[i]  <= stable & ~level[i];
                end
            end
        end
    endgenerate

endmodule

// file: wtc_watchdog_top.sv
// watchdog supervisor with guarded control register on apb
`timescale 1ns/1ns
`include "wtc_map.svh"
module wtc_watchdog_top
    import wtc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        xtal_32k,
    input  wire logic        supply_monitor,
    output logic             wdt_reset_req,
    output logic             wdt_nmi_req,
    output logic             irq
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
        addr_hit = (addr[11:2] == off[11:2]);
    endfunction

    // last count before expiry: 2^(code+9)-1, so a period of 2^(code+9) crystal ticks
    function automatic logic [15:0] period_limit(input logic [3:0] code);
        logic [2:0] shift;
        shift        = 3'(`WTC_PRE_MAX - code);
        period_limit = `WTC_CNT_FULL >> shift;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wtc_ctrl_t    ctrl;
    wtc_ctrl_t    next_ctrl;
    wtc_lock_t    lock_state;
    wtc_lock_t    next_lock_state;
    logic [15:0]  cnt;
    logic [15:0]  next_cnt;
    wtc_evt_t     stat;
    wtc_evt_t     next_stat;
    wtc_evt_t     ien;
    wtc_evt_t     next_ien;
    wtc_apb_req_t req;

    // ----------------------------------------------------------------
    // pin synchronisers: crystal and supply monitor
    // ----------------------------------------------------------------
    logic [1:0] pin_rise;

    wtc_pin_sync #(
        .N (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({supply_monitor, xtal_32k}),
        .level   (),
        .rise    (pin_rise)
    );

    // crystal is far slower than pclk, so one rising edge gives one tick
    wire tick        = pin_rise[0];
    wire supply_rise = pin_rise[1];

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    wire setup    = req.sel & ~req.enable;
    wire access   = req.sel & req.enable & pready;
    wire hit_ctrl = addr_hit(req.addr, `WTC_OFF_CTRL);
    wire hit_stat = addr_hit(req.addr, `WTC_OFF_STAT);
    wire hit_iclr = addr_hit(req.addr, `WTC_OFF_ICLR);
    wire hit_ien  = addr_hit(req.addr, `WTC_OFF_IEN);
    wire mapped   = hit_ctrl | hit_stat | hit_iclr | hit_ien;
    wire wr_ctrl  = access & req.write & hit_ctrl;
    wire wr_iclr  = access & req.write & hit_iclr;
    wire wr_ien   = access & req.write & hit_ien;

    wire w_unlock = req.wdata[`WTC_BIT_UNLOCK];
    wire w_run    = req.wdata[`WTC_BIT_RUN];
    wire w_flag   = req.wdata[`WTC_BIT_FLAG];
    wire w_irqm   = req.wdata[`WTC_BIT_IRQM];
    wire [3:0] w_pre = req.wdata[`WTC_PRE_MSB:`WTC_PRE_LSB];

    // ----------------------------------------------------------------
    // two-step unlock
    // ----------------------------------------------------------------
    wire lock_idle   = (lock_state == LOCK_IDLE);
    wire unlock_req  = wr_ctrl & lock_idle & w_unlock;
    wire guarded_wr  = wr_ctrl & ~lock_idle;
    wire rejected_wr = wr_ctrl & lock_idle & ~w_unlock;

    // any completed transfer consumes the unlock, even a read elsewhere
    always_comb begin
        next_lock_state = lock_state;
        case (lock_state)
            LOCK_IDLE: begin
                if (unlock_req) begin
                    next_lock_state = LOCK_ARMED;
                end
            end
            LOCK_ARMED: begin
                if (access) begin
                    next_lock_state = LOCK_IDLE;
                end
            end
            default: begin
                next_lock_state = LOCK_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // counter and timeout
    // ----------------------------------------------------------------
    wire [15:0] limit      = period_limit(ctrl.timeout_prescale_sel);
    wire        pre_valid  = (ctrl.timeout_prescale_sel <= `WTC_PRE_MAX);
    wire        pre_imm    = (ctrl.timeout_prescale_sel == `WTC_PRE_IMM);
    wire        run        = ctrl.run_and_kick_bit;
    wire        kick       = guarded_wr & w_run;
    // reserved codes above 8 stall the counter and never expire
    wire        expire     = run & ((pre_valid & tick & (cnt == limit)) | pre_imm);
    wire        exp_reset  = expire & (pre_imm | ~ctrl.irq_instead_of_reset);
    wire        exp_irq    = expire & ~pre_imm & ctrl.irq_instead_of_reset;

    always_comb begin
        if (kick | expire | ~run) begin
            next_cnt = 16'h0000;
        end else if (tick & pre_valid) begin
            next_cnt = cnt + 16'h0001;
        end else begin
            next_cnt = cnt;
        end
    end

    // ----------------------------------------------------------------
    // control register update
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_ctrl.write_unlock_bit = 1'b0;
        if (guarded_wr) begin
            next_ctrl.timeout_prescale_sel = w_pre;
            next_ctrl.irq_instead_of_reset = w_irqm;
            next_ctrl.run_and_kick_bit     = w_run;
            if (!w_flag) begin
                next_ctrl.timeout_flag = 1'b0;
            end
        end
        // clears of the run bit win over a same-cycle write of one
        if (exp_reset | supply_rise) begin
            next_ctrl.run_and_kick_bit = 1'b0;
        end
        // set wins over the software clear
        if (expire) begin
            next_ctrl.timeout_flag = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, clear and enable
    // ----------------------------------------------------------------
    wire [1:0] evt_now = {rejected_wr, expire};
    wire [1:0] clr_bits = wr_iclr ? req.wdata[1:0] : 2'h0;

    assign next_stat = wtc_evt_t'((stat & ~clr_bits) | evt_now);
    assign next_ien  = wr_ien ? wtc_evt_t'(req.wdata[1:0]) : ien;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wtc_ctrl_t ctrl_view;
    always_comb begin
        ctrl_view = ctrl;
        ctrl_view.write_unlock_bit = ~lock_idle;
    end

    wire [31:0] rd_ctrl = {24'h00_0000, ctrl_view};
    wire [31:0] rd_stat = {30'h0000_0000, stat};
    wire [31:0] rd_ien  = {30'h0000_0000, ien};
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                          hit_stat ? rd_stat :
                          hit_ien  ? rd_ien  : 32'h0000_0000;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= wtc_ctrl_t'(`WTC_CTRL_RESET);
            lock_state <= LOCK_IDLE;
            cnt        <= 16'h0000;
            stat       <= wtc_evt_t'(`WTC_EVT_RESET);
            ien        <= wtc_evt_t'(`WTC_EVT_RESET);
        end else begin
            ctrl       <= next_ctrl;
            lock_state <= next_lock_state;
            cnt        <= next_cnt;
            stat       <= next_stat;
            ien        <= next_ien;
        end
    end

    // no wait state: data prepared in setup, answered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup ? rd_data : 32'h0000_0000;
        end
    end

    // nmi stays off the maskable line on purpose
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_req <= 1'b0;
            wdt_nmi_req   <= 1'b0;
            irq           <= 1'b0;
        end else begin
            wdt_reset_req <= exp_reset;
            wdt_nmi_req   <= next_ctrl.timeout_flag & next_ctrl.irq_instead_of_reset;
            irq           <= |(next_stat & next_ien);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    irq_mode_a: assert property (exp_irq |=> wdt_nmi_req && !wdt_reset_req)
        else $error("interrupt-mode timeout did not raise nmi");

    nmi_unmasked_a: assert property (ctrl.timeout_flag && ctrl.irq_instead_of_reset |-> wdt_nmi_req)
        else $error("nmi missing while flag set in interrupt mode");

    periodic_restart_a: assert property (exp_irq && !supply_rise |=> cnt == 16'h0000 && run)
        else $error("periodic timer did not restart");

    flag_set_a: assert property (expire |=> ctrl.timeout_flag)
        else $error("timeout flag not set");

    timeout_status_a: assert property (expire |=> stat.timeout)
        else $error("timeout status bit not set");

    reject_status_a: assert property (rejected_wr |=> stat.rejected)
        else $error("rejected write not reported");

    flag_hold_a: assert property (ctrl.timeout_flag && !(guarded_wr && !w_flag) |=> ctrl.timeout_flag)
        else $error("timeout flag lost without clear");

    kick_restart_a: assert property (kick && !expire && !supply_rise |=> cnt == 16'h0000 && run)
        else $error("run write did not restart counter");

    reset_pulse_a: assert property (exp_reset |=> wdt_reset_req ##1 !wdt_reset_req)
        else $error("reset request not a single pulse");

    run_clear_a: assert property (exp_reset || supply_rise |=> !ctrl.run_and_kick_bit)
        else $error("run bit not cleared");

    guard_hold_a: assert property (wr_ctrl && lock_idle |=>
                                   $stable(ctrl.timeout_prescale_sel) && $stable(ctrl.irq_instead_of_reset))
        else $error("unguarded write changed control register");

    unlock_expire_a: assert property (!lock_idle && access |=> lock_state == LOCK_IDLE)
        else $error("unlock outlived one transfer");

    count_bound_a: assert property (run && pre_valid |-> cnt <= limit)
        else $error("counter passed selected period");

    immediate_reset_a: assert property (run && pre_imm |=> wdt_reset_req)
        else $error("code 8 did not reset at once");

endmodule

// file: wtc_testbench.sv
// self-checking testbench of the watchdog supervisor
`timescale 1ns/1ns
`include "wtc_map.svh"
module testbench;
    import wtc_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and observation signals
    // ----------------------------------------------------------------
    logic        pclk           = 1'b0;
    logic        presetn        = 1'b0;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [11:0] paddr          = 12'h000;
    logic [31:0] pwdata         = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        xtal_32k       = 1'b0;
    logic        supply_monitor = 1'b0;
    logic        wdt_reset_req;
    logic        wdt_nmi_req;
    logic        irq;
    int          error_cnt      = 0;
    int          total_checks   = 0;
    int          rst_pulses     = 0;
    logic [31:0] rd;
    logic        err;

    always #25 pclk = ~pclk;

    wtc_watchdog_top i_wtc_watchdog_top (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .xtal_32k       (xtal_32k),
        .supply_monitor (supply_monitor),
        .wdt_reset_req  (wdt_reset_req),
        .wdt_nmi_req    (wdt_nmi_req),
        .irq            (irq)
    );

    // one-cycle pulses are counted here so no scenario can miss them
    always @(posedge pclk) begin
        if (wdt_reset_req === 1'b1) begin
            rst_pulses++;
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // request held until pready is sampled high; bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (n == 20) begin
            error_cnt++;
            $display("ERROR %0t no bus answer", $time);
            summarize();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, what);
    endtask

    // unlock step then the guarded control write
    task automatic gw(input logic [7:0] d);
        apb(1'b1, `WTC_OFF_CTRL, 32'h0000_0001);
        apb(1'b1, `WTC_OFF_CTRL, {24'h00_0000, d});
    endtask

    // crystal ticks, eight pclk each; extra cycles cover the synchroniser
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge pclk) xtal_32k <= 1'b1;
            repeat (4) @(posedge pclk) xtal_32k <= 1'b0;
        end
        repeat (8) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_guard();
        rdc(`WTC_OFF_CTRL, 32'h0000_0010, "ctrl reset value");
        apb(1'b1, `WTC_OFF_CTRL, 32'h0000_000A);
        rdc(`WTC_OFF_CTRL, 32'h0000_0010, "unguarded write");
        apb(1'b1, `WTC_OFF_CTRL, 32'h0000_0001);
        rdc(`WTC_OFF_STAT, 32'h0000_0002, "read wastes unlock");
        apb(1'b1, `WTC_OFF_CTRL, 32'h0000_000A);
        rdc(`WTC_OFF_CTRL, 32'h0000_0010, "stale unlock");
        gw(8'h0A);
        rdc(`WTC_OFF_CTRL, 32'h0000_000A, "guarded write");
    endtask

    // interrupt mode, prescale 0: 512 ticks per period
    task automatic t_irq_mode();
        ticks(511);
        chk({31'h0, wdt_nmi_req}, 32'h0, "nmi before period end");
        ticks(1);
        chk({31'h0, wdt_nmi_req}, 32'h1, "nmi with enable reg 0");
        chk(rst_pulses, 0, "no reset in irq mode");
        rdc(`WTC_OFF_CTRL, 32'h0000_000E, "flag set, run kept");
        gw(8'h0A);
        @(posedge pclk);
        chk({31'h0, wdt_nmi_req}, 32'h0, "flag cleared by zero");
        ticks(500);
        chk({31'h0, wdt_nmi_req}, 32'h0, "second period early");
        ticks(12);
        chk({31'h0, wdt_nmi_req}, 32'h1, "periodic interrupt");
    endtask

    task automatic t_reset_mode();
        gw(8'h02);
        ticks(300);
        gw(8'h02);
        ticks(300);
        chk(rst_pulses, 0, "kick restarts counter");
        ticks(212);
        chk(rst_pulses, 1, "reset on expiry");
        rdc(`WTC_OFF_CTRL, 32'h0000_0004, "run cleared, flag kept");
        gw(8'h82);
        repeat (6) @(posedge pclk);
        chk(rst_pulses, 2, "immediate reset code");
        rdc(`WTC_OFF_CTRL, 32'h0000_0084, "code 8 state");
        gw(8'h92);
        ticks(600);
        chk(rst_pulses, 2, "reserved code no timeout");
    endtask

    task automatic t_supply();
        gw(8'h02);
        @(posedge pclk) supply_monitor <= 1'b1;
        repeat (4) @(posedge pclk);
        supply_monitor <= 1'b0;
        repeat (6) @(posedge pclk);
        rdc(`WTC_OFF_CTRL, 32'h0000_0000, "supply monitor clears run");
        gw(8'h02);
        rdc(`WTC_OFF_CTRL, 32'h0000_0002, "run set again");
        gw(8'h00);
        rdc(`WTC_OFF_CTRL, 32'h0000_0000, "run written zero");
    endtask

    task automatic t_events();
        rdc(`WTC_OFF_STAT, 32'h0000_0003, "status sticky");
        apb(1'b1, `WTC_OFF_ICLR, 32'h0000_0003);
        rdc(`WTC_OFF_STAT, 32'h0000_0000, "status cleared");
        apb(1'b1, `WTC_OFF_IEN, 32'h0000_0002);
        rdc(`WTC_OFF_IEN, 32'h0000_0002, "enable readback");
        apb(1'b1, `WTC_OFF_CTRL, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "rejected write raises irq");
        apb(1'b1, `WTC_OFF_IEN, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, `WTC_OFF_IEN, 32'h0000_0002);
        apb(1'b1, `WTC_OFF_ICLR, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "cleared irq");
        rdc(`WTC_OFF_ICLR, 32'h0000_0000, "clear reg reads zero");
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
    endtask

    task automatic t_hw_reset();
        gw(8'h8A);
        repeat (6) @(posedge pclk);
        rdc(`WTC_OFF_CTRL, 32'h0000_008C, "flag before hw reset");
        chk(rst_pulses, 3, "code 8 resets in irq mode");
        chk({31'h0, wdt_nmi_req}, 32'h1, "nmi level with flag");
        @(posedge pclk) presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`WTC_OFF_CTRL, 32'h0000_0010, "hw reset clears flag");
        chk({31'h0, wdt_nmi_req}, 32'h0, "nmi off after hw reset");
    endtask

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_guard();
        t_irq_mode();
        t_reset_mode();
        t_supply();
        t_events();
        t_hw_reset();
        summarize();
    end

    initial begin
        #(50 * 90000);
        error_cnt++;
        $display("ERROR %0t run limit reached", $time);
        summarize();
    end

endmodule
